// ### bench/csic_card_model.sv
// Behavioural card in the socket: drives the six card pins
`default_nettype none
module csic_card_model (
   // Clock
   input  wire logic                    clk_in,
   // Card pins
   output var csic_pkg::csic_pins_type  pins_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial pins_out = '0;

   ////////////////////////////////////////////////////////////////////////////
   // Long enough on each level to outlast the two-flop synchroniser
   task automatic pulse(input int idx);
      @(posedge clk_in);
      pins_out[idx] <= 1'b1;
      repeat (6) @(posedge clk_in);
      pins_out[idx] <= 1'b0;
      repeat (6) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// ### bench/csic_top_test.sv
// Self-checking bench of the status-change interrupt block
`default_nettype none
module csic_top_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic                    clk_in;
   logic                    rst_in;
   logic                    psel;
   logic                    penable;
   logic                    pwrite;
   logic [7:0]              paddr;
   logic [31:0]             pwdata;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   csic_pkg::csic_pins_type pins;
   logic                    irq;
   logic [15:0]             legacy;
   logic                    system_management_irq;
   logic                    host;
   int                      num_errors;
   int                      cmp_count;

   csic_top csic_top_i (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .card_pins_in(pins),
      .irq_out(irq), .legacy_irq_out(legacy),
      .system_management_irq_out(system_management_irq), .host_bus_irq_out(host)
   );

   csic_card_model csic_card_model_i (
      .clk_in(clk_in), .pins_out(pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   task automatic end_sim;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // APB master; waits for pready, never assumes a latency
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge clk_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         chk(32'h0000_0000, 32'h0000_0001);
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, exp);
   endtask

   // Expected interrupt outputs packed as irq, legacy lines, smi, host
   function automatic logic [31:0] route_exp(input logic [3:0] sel,
                                             input logic [1:0] rt,
                                             input logic       pend);
      logic [15:0] lg;
      logic        sm;
      logic        hb;
      lg = '0;
      sm = 1'b0;
      hb = 1'b0;
      if (pend) begin
         if (sel == csic_pkg::SEL_NONE) hb = |rt;
         else if (sel == csic_pkg::SEL_SMI) sm = 1'b1;
         else lg[sel] = 1'b1;
      end
      return {13'h0, pend, lg, sm, hb};
   endfunction

   function automatic logic [31:0] outs();
      return {13'h0, irq, legacy, system_management_irq, host};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_reset;
      logic [31:0] r;
      logic        e;
      chk(outs(), route_exp(4'h0, 2'h0, 1'b0));
      rd(csic_pkg::ADDR_CONFIG, 32'h0000_0000);
      rd(csic_pkg::ADDR_ROUTE, 32'h0000_0000);
      rd(csic_pkg::ADDR_STATUS, 32'h0000_0000);
      rd(csic_pkg::ADDR_MASK, 32'h0000_0000);
      rd(csic_pkg::ADDR_PINS, 32'h0000_0000);
      wr(8'h14, 32'hffff_ffff);
      apb(1'b0, 8'h14, 32'h0000_0000, r, e);
      chk({r[30:0], e}, 32'h0000_0001);
   endtask

   // Each source: lost while disabled, latched and read-cleared when enabled
   task automatic test_sources;
      int pin_of[5] = '{5, 4, 3, 2, 1};
      int bit_of[5] = '{3, 3, 2, 1, 0};
      for (int k = 0; k < 5; k++) begin
         wr(csic_pkg::ADDR_CONFIG, 32'h0000_0000);
         csic_card_model_i.pulse(pin_of[k]);
         rd(csic_pkg::ADDR_STATUS, 32'h0000_0000);
         wr(csic_pkg::ADDR_CONFIG, 32'h1 << bit_of[k]);
         csic_card_model_i.pulse(pin_of[k]);
         rd(csic_pkg::ADDR_STATUS, 32'h1 << bit_of[k]);
         rd(csic_pkg::ADDR_STATUS, 32'h0000_0000);
      end
   endtask

   // An I/O card swaps the bit-0 source to the status-change signal
   task automatic test_io_card;
      wr(csic_pkg::ADDR_ROUTE, 32'h0000_0001);
      wr(csic_pkg::ADDR_CONFIG, 32'h0000_0000);
      csic_card_model_i.pulse(0);
      rd(csic_pkg::ADDR_STATUS, 32'h0000_0000);
      wr(csic_pkg::ADDR_CONFIG, 32'h0000_0001);
      csic_card_model_i.pulse(0);
      rd(csic_pkg::ADDR_STATUS, 32'h0000_0001);
      csic_card_model_i.pulse(1);
      rd(csic_pkg::ADDR_STATUS, 32'h0000_0000);
      wr(csic_pkg::ADDR_ROUTE, 32'h0000_0000);
   endtask

   // Pending ready event held while every select code and route is tried
   task automatic test_routing;
      wr(csic_pkg::ADDR_MASK, 32'h0000_0000);
      wr(csic_pkg::ADDR_CONFIG, 32'h0000_0004);
      csic_card_model_i.pulse(3);
      chk(outs(), route_exp(4'h0, 2'h0, 1'b0));
      wr(csic_pkg::ADDR_MASK, 32'h0000_000f);
      for (int s = 0; s < 16; s++) begin
         for (int r = 0; r < 4; r++) begin
            wr(csic_pkg::ADDR_ROUTE, 32'(r) << 4);
            wr(csic_pkg::ADDR_CONFIG, (32'(s) << 4) | 32'h4);
            repeat (3) @(posedge clk_in);
            chk(outs(), route_exp(4'(s), 2'(r), 1'b1));
         end
      end
      rd(csic_pkg::ADDR_STATUS, 32'h0000_0004);
      repeat (3) @(posedge clk_in);
      chk(outs(), route_exp(4'hf, 2'h3, 1'b0));
      // A fresh ready rise with the mask open reaches line 15 directly
      csic_card_model_i.pulse(3);
      chk(outs(), route_exp(4'hf, 2'h3, 1'b1));
      rd(csic_pkg::ADDR_STATUS, 32'h0000_0004);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      num_errors = 0;
      cmp_count  = 0;
      rst_in  = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      test_reset();
      test_sources();
      test_io_card();
      test_routing();
      end_sim();
   end

   // Whole run needs well under 10000 cycles
   initial begin
      repeat (40000) @(posedge clk_in);
      num_errors++;
      end_sim();
   end
endmodule
`default_nettype wire

// ### hdl/csic_pkg.sv
// Package: register map, field positions and carriers of the status irq block
`default_nettype none
package csic_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses on the APB port
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_ROUTE  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_MASK   = 8'h0c;
   localparam logic [7:0] ADDR_PINS   = 8'h10;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions of the config register and of status and mask
   localparam int SEL_LSB        = 4;
   localparam int DETECT_EN_BIT  = 3;
   localparam int READY_EN_BIT   = 2;
   localparam int WARN_EN_BIT    = 1;
   localparam int DEAD_EN_BIT    = 0;

   // Field positions of the route register
   localparam int DIAG_ROUTE_BIT = 5;
   localparam int HOST_ROUTE_BIT = 4;
   localparam int IO_CARD_BIT    = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Select codes with a fixed meaning
   localparam logic [3:0] SEL_NONE  = 4'h0;
   localparam logic [3:0] SEL_LINE1 = 4'h1;
   localparam logic [3:0] SEL_SMI   = 4'h2;
   localparam logic [3:0] SEL_LINE3 = 4'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset, cycles before arming, and counts of pins and lines
   localparam logic [7:0]  CONFIG_RESET = 8'h00;
   localparam logic [7:0]  ROUTE_RESET  = 8'h00;
   localparam logic [3:0]  STATUS_RESET = 4'h0;
   localparam logic [3:0]  MASK_RESET   = 4'h0;
   localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;
   localparam logic [1:0]  ARM_CYCLES   = 2'h3;
   localparam int          PIN_COUNT    = 6;
   localparam int          LINE_COUNT   = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Card pins, active high, as seen at the socket
   typedef struct packed {
      logic detect_first;
      logic detect_second;
      logic ready;
      logic batt_warn;
      logic batt_dead;
      logic card_status_change_signal;
   } csic_pins_type;

   // Layout of the config register
   typedef struct packed {
      logic [3:0] status_irq_select;
      logic       detect_change_irq_en;
      logic       ready_rise_irq_en;
      logic       batt_warn_irq_en;
      logic       batt_dead_irq_en;
   } csic_cfg_type;

endpackage
`default_nettype wire

// ### hdl/csic_sync.sv
// Module: two flip-flop synchroniser for the asynchronous card pins
`default_nettype none
module csic_sync #(
   parameter int WIDTH = 6
) (
   // Clock, reset, enable
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             ce_in,
   // Data
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // First stage feeds only the second stage
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
               meta_reg[i] <= 1'h0;
               sync_reg[i] <= 1'h0;
            end else if (ce_in) begin
               meta_reg[i] <= d_in[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

   assign q_out = sync_reg;

endmodule
`default_nettype wire

// ### hdl/csic_top.sv
// Module: card status-change interrupt enables, latching and routing
`default_nettype none
module csic_top (
   // Clock, reset, enable
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     ce_in,
   // APB slave
   input  wire logic                     psel_in,
   input  wire logic                     penable_in,
   input  wire logic                     pwrite_in,
   input  wire logic [7:0]               paddr_in,
   input  wire logic [31:0]              pwdata_in,
   output logic      [31:0]              prdata_out,
   output logic                          pready_out,
   output logic                          pslverr_out,
   // Card pins, asynchronous
   input  wire csic_pkg::csic_pins_type  card_pins_in,
   // Interrupt outputs
   output logic                          irq_out,
   output logic      [15:0]              legacy_irq_out,
   output logic                          system_management_irq_out,
   output logic                          host_bus_irq_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0]              config_reg;
   logic [7:0]              route_reg;
   logic [3:0]              status_reg;
   logic [3:0]              status_next;
   logic [3:0]              mask_reg;
   logic [31:0]             prdata_reg;
   logic                    pready_reg;
   logic                    pslverr_reg;
   logic                    irq_reg;
   logic [15:0]             legacy_reg;
   logic [15:0]             legacy_next;
   logic                    smi_reg;
   logic                    host_reg;
   logic [1:0]              arm_cnt_reg;
   logic                    armed;
   logic [5:0]              pins_raw;
   csic_pkg::csic_pins_type pins;
   csic_pkg::csic_pins_type prev_reg;
   csic_pkg::csic_cfg_type  cfg;
   logic                    io_card;
   logic                    diag_route;
   logic                    host_route;
   logic                    dead_now;
   logic                    dead_prev;
   logic [3:0]              ev_raw;
   logic [3:0]              ev_en;
   logic [3:0]              ev_set;
   logic                    pend;
   logic                    access;
   logic                    done;
   logic                    wr_done;
   logic                    mapped;
   logic [31:0]             rd_data;
   logic [3:0]              sel;

   assign cfg        = csic_pkg::csic_cfg_type'(config_reg);
   assign sel        = cfg.status_irq_select;
   assign io_card    = route_reg[csic_pkg::IO_CARD_BIT];
   assign diag_route = route_reg[csic_pkg::DIAG_ROUTE_BIT];
   assign host_route = route_reg[csic_pkg::HOST_ROUTE_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // APB: one wait cycle so read data comes from a register
   assign access  = psel_in & penable_in & ~pready_reg;
   assign done    = psel_in & penable_in & pready_reg;
   assign wr_done = done & pwrite_in & mapped;

   always_comb begin
      mapped = 1'h1;
      unique case (paddr_in)
         csic_pkg::ADDR_CONFIG: rd_data = {24'h00_0000, config_reg};
         csic_pkg::ADDR_ROUTE:  rd_data = {24'h00_0000, route_reg};
         csic_pkg::ADDR_STATUS: rd_data = {28'h000_0000, status_reg};
         csic_pkg::ADDR_MASK:   rd_data = {28'h000_0000, mask_reg};
         csic_pkg::ADDR_PINS:   rd_data = {26'h00_0000, pins};
         default: begin
            rd_data = 32'h0000_0000;
            mapped  = 1'h0;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pready_reg  <= 1'h0;
         pslverr_reg <= 1'h0;
         prdata_reg  <= csic_pkg::RDATA_RESET;
      end else if (ce_in) begin
         pready_reg  <= access;
         pslverr_reg <= access & ~mapped;
         if (access && !pwrite_in) begin
            prdata_reg <= rd_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writable registers; all enables and the select clear at reset
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         config_reg <= csic_pkg::CONFIG_RESET;
      end else if (ce_in && wr_done &&
                   paddr_in == csic_pkg::ADDR_CONFIG) begin
         config_reg <= pwdata_in[7:0];
      end
   end

   // Reserved route bits read as zero
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         route_reg <= csic_pkg::ROUTE_RESET;
      end else if (ce_in && wr_done &&
                   paddr_in == csic_pkg::ADDR_ROUTE) begin
         route_reg <= 8'h00;
         route_reg[csic_pkg::DIAG_ROUTE_BIT] <=
            pwdata_in[csic_pkg::DIAG_ROUTE_BIT];
         route_reg[csic_pkg::HOST_ROUTE_BIT] <=
            pwdata_in[csic_pkg::HOST_ROUTE_BIT];
         route_reg[csic_pkg::IO_CARD_BIT] <=
            pwdata_in[csic_pkg::IO_CARD_BIT];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mask_reg <= csic_pkg::MASK_RESET;
      end else if (ce_in && wr_done &&
                   paddr_in == csic_pkg::ADDR_MASK) begin
         mask_reg <= pwdata_in[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Card pins: synchronise, then compare with the last sample
   csic_sync #(
      .WIDTH (csic_pkg::PIN_COUNT)
   ) u_sync (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .d_in   (card_pins_in),
      .q_out  (pins_raw)
   );

   assign pins = csic_pkg::csic_pins_type'(pins_raw);

   // Edges are ignored until the sync chain and last sample hold real pins,
   // so a card present at reset does not look like an insertion
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         arm_cnt_reg <= 2'h0;
         prev_reg    <= '0;
      end else if (ce_in) begin
         prev_reg <= pins;
         if (!armed) begin
            arm_cnt_reg <= arm_cnt_reg + 2'h1;
         end
      end
   end

   assign armed = (arm_cnt_reg == csic_pkg::ARM_CYCLES);

   // Source of bit 0 depends on the card type
   assign dead_now  = io_card ? pins.card_status_change_signal
                              : pins.batt_dead;
   assign dead_prev = io_card ? prev_reg.card_status_change_signal
                              : prev_reg.batt_dead;

   // Sample and last sample both follow the card type, so switching it while
   // the two sources differ gives no spurious bit 0 event by itself
   always_comb begin
      ev_raw = 4'h0;
      ev_raw[csic_pkg::DETECT_EN_BIT] =
         (pins.detect_first  ^ prev_reg.detect_first) |
         (pins.detect_second ^ prev_reg.detect_second);
      ev_raw[csic_pkg::READY_EN_BIT] =
         pins.ready & ~prev_reg.ready;
      ev_raw[csic_pkg::WARN_EN_BIT] =
         pins.batt_warn & ~prev_reg.batt_warn;
      ev_raw[csic_pkg::DEAD_EN_BIT] = dead_now & ~dead_prev;
      if (!armed) begin
         ev_raw = 4'h0;
      end
   end

   assign ev_en = {cfg.detect_change_irq_en, cfg.ready_rise_irq_en,
                   cfg.batt_warn_irq_en, cfg.batt_dead_irq_en};
   assign ev_set = ev_raw & ev_en;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status; a read clears it, but a new event in that cycle stays
   always_comb begin
      status_next = status_reg;
      if (done && !pwrite_in && paddr_in == csic_pkg::ADDR_STATUS) begin
         status_next = 4'h0;
      end
      status_next = status_next | ev_set;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         status_reg <= csic_pkg::STATUS_RESET;
      end else if (ce_in) begin
         status_reg <= status_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Routing of the one combined status-change interrupt
   assign pend = |(status_reg & mask_reg);

   genvar n;
   generate
      for (n = 0; n < csic_pkg::LINE_COUNT; n = n + 1) begin : g_line
         // Code 0 is no line and code 2 is the management irq
         assign legacy_next[n] = pend && sel == 4'(n) &&
                                 sel != csic_pkg::SEL_NONE &&
                                 sel != csic_pkg::SEL_SMI;
      end
   endgenerate

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_reg    <= 1'h0;
         legacy_reg <= 16'h0000;
         smi_reg    <= 1'h0;
         host_reg   <= 1'h0;
      end else if (ce_in) begin
         irq_reg    <= pend;
         legacy_reg <= legacy_next;
         smi_reg    <= pend && sel == csic_pkg::SEL_SMI;
         host_reg   <= pend && sel == csic_pkg::SEL_NONE &&
                       (diag_route || host_route);
      end
   end

   assign prdata_out                = prdata_reg;
   assign pready_out                = pready_reg;
   assign pslverr_out               = pslverr_reg;
   assign irq_out                   = irq_reg;
   assign legacy_irq_out            = legacy_reg;
   assign system_management_irq_out = smi_reg;
   assign host_bus_irq_out          = host_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence seq_ready_rise;
      ce_in && armed && pins.ready && !prev_reg.ready &&
      cfg.ready_rise_irq_en;
   endsequence

   sequence seq_ready_reaches_irq;
      seq_ready_rise ##1
      ce_in && mask_reg[csic_pkg::READY_EN_BIT];
   endsequence

   chk_none_route: assert property (
      ce_in && sel == csic_pkg::SEL_NONE |=>
      legacy_reg == 16'h0000 && !smi_reg)
      else $error("select 0000 drove a legacy line or management irq");

   chk_line_one: assert property (
      ce_in && pend && sel == csic_pkg::SEL_LINE1 |=>
      legacy_reg == 16'h0002 && !smi_reg && !host_reg)
      else $error("code 0001 did not drive line 1 alone");

   chk_smi_route: assert property (
      ce_in && pend && sel == csic_pkg::SEL_SMI |=>
      smi_reg && legacy_reg == 16'h0000)
      else $error("code 0010 did not drive management irq alone");

   chk_line_three: assert property (
      ce_in && pend && sel == csic_pkg::SEL_LINE3 |=>
      legacy_reg == 16'h0008)
      else $error("code 0011 did not drive line 3");

   chk_detect_gate: assert property (
      ce_in && !cfg.detect_change_irq_en &&
      !status_reg[csic_pkg::DETECT_EN_BIT] |=>
      !status_reg[csic_pkg::DETECT_EN_BIT])
      else $error("detect change latched while disabled");

   chk_detect_set: assert property (
      ce_in && armed && cfg.detect_change_irq_en &&
      pins.detect_second != prev_reg.detect_second |=>
      status_reg[csic_pkg::DETECT_EN_BIT])
      else $error("enabled detect change was not latched");

   chk_ready_rise: assert property (
      seq_ready_rise |=> status_reg[csic_pkg::READY_EN_BIT])
      else $error("enabled ready rise was not latched");

   chk_ready_path: assert property (
      seq_ready_reaches_irq |=> irq_reg)
      else $error("ready event did not reach the interrupt");

   chk_warn_gate: assert property (
      ce_in && !cfg.batt_warn_irq_en &&
      !status_reg[csic_pkg::WARN_EN_BIT] |=>
      !status_reg[csic_pkg::WARN_EN_BIT])
      else $error("battery warning latched while disabled");

   chk_dead_source: assert property (
      ce_in && armed && cfg.batt_dead_irq_en &&
      (io_card ? pins.card_status_change_signal &&
                 !prev_reg.card_status_change_signal
               : pins.batt_dead && !prev_reg.batt_dead) |=>
      status_reg[csic_pkg::DEAD_EN_BIT])
      else $error("enabled bit 0 source was not latched");

   chk_diag_route: assert property (
      ce_in && pend && sel == csic_pkg::SEL_NONE && diag_route |=>
      host_reg)
      else $error("diag bit set but host bus irq missing");

   chk_host_route: assert property (
      ce_in && pend && sel == csic_pkg::SEL_NONE && !diag_route |=>
      host_reg == $past(host_route))
      else $error("host bus irq does not follow route bit");

   chk_high_codes: assert property (
      ce_in && pend && sel > csic_pkg::SEL_LINE3 |=>
      legacy_reg == (16'h0001 << $past(sel)) && !smi_reg)
      else $error("higher code drove the wrong legacy line");

endmodule
`default_nettype wire
